// File: design/aog_core.sv
// apb-controlled operand and address generator
`timescale 1ns/10ps
module aog_core import aog_pkg::*; (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AOG_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // results
  output logic      [31:0]       second_operand,
  output logic                   shifter_carry,
  output logic      [31:0]       access_addr,
  output logic      [31:0]       writeback_addr,
  output logic                   writeback_en,
  output logic      [31:0]       end_addr,
  output logic      [3:0]        field_en,
  output logic                   illegal_form,
  output logic                   result_valid
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] base;
    logic [31:0] index;
    logic [31:0] shreg;
    logic [31:0] imm;
    aog_state_t  st;
    logic        illegal;
    logic        done;
    logic        carry;
    logic        wb_en;
    logic        valid;
    logic [31:0] op2;
    logic [31:0] addr;
    logic [31:0] wb_addr;
    logic [31:0] end_addr;
    logic [3:0]  fen;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } aog_regs_t;

  aog_regs_t r;
  aog_regs_t n;

  // decoded control
  aog_mode_t   mode;
  aog_form_t   form;
  aog_src_t    src;
  aog_kind_t   kind;
  aog_seq_t    seq;
  logic        up;
  logic        by_reg;
  logic [7:0]  sh_amt;
  logic [31:0] sh_res;
  logic        sh_c;
  // computed results
  logic [31:0] ofs;
  logic [31:0] calc;
  logic [31:0] nbytes;
  logic [31:0] c_op2;
  logic [31:0] c_addr;
  logic [31:0] c_wb;
  logic [31:0] c_end;
  logic        c_wben;
  logic        c_ill;
  logic [3:0]  c_fen;
  // bus
  logic        acc;
  logic        hit;
  logic [31:0] rdval;
  logic [31:0] status;

  assign mode   = aog_mode_t'(r.ctrl[C_MODE +: 3]);
  assign form   = aog_form_t'(r.ctrl[C_FORM +: 2]);
  assign src    = aog_src_t'(r.ctrl[C_SRC +: 2]);
  assign kind   = aog_kind_t'(r.ctrl[C_KIND +: 3]);
  assign seq    = aog_seq_t'(r.ctrl[C_SEQ +: 2]);
  assign up     = r.ctrl[C_UP];
  assign by_reg = r.ctrl[C_BYREG];

  // register amounts only for the second operand
  always_comb begin
    if (by_reg && mode == AOG_M_OPERAND) begin
      sh_amt = r.shreg[7:0];
    end else begin
      sh_amt = {3'h0, r.ctrl[C_SHIMM +: SHIMM_W]};
    end
  end

  aog_shifter u_shift (
    .value    (r.index),
    .kind     (kind),
    .amount   (sh_amt),
    .carry_in (r.ctrl[C_CIN]),
    .result   (sh_res),
    .carry_out(sh_c)
  );

  // offset selection per addressing mode
  always_comb begin
    ofs = r.index;
    c_ill = 1'b0;
    case (mode)
      AOG_M_WORD_BYTE, AOG_M_UNPRIV: begin
        case (src)
          AOG_S_IMM:    ofs = {20'h0, r.imm[OFS12_W-1:0]};
          AOG_S_REG:    ofs = r.index;
          AOG_S_SCALED: ofs = sh_res;
          default:      c_ill = 1'b1;
        endcase
        if (mode == AOG_M_UNPRIV && form == AOG_F_PRE) begin
          c_ill = 1'b1;
        end
      end
      AOG_M_HALFWORD: begin
        case (src)
          AOG_S_IMM: ofs = {24'h0, r.imm[OFS8_W-1:0]};
          AOG_S_REG: ofs = r.index;
          default:   c_ill = 1'b1;
        endcase
      end
      AOG_M_COPROC: begin
        ofs = {22'h0, r.imm[OFS8_W-1:0], 2'h0};
      end
      default: ofs = r.index;
    endcase
    if (form != AOG_F_OFFSET && form != AOG_F_PRE && form != AOG_F_POST) begin
      c_ill = 1'b1;
    end
  end

  assign calc   = up ? r.base + ofs : r.base - ofs;
  assign nbytes = {25'h0, r.imm[CNT_W-1:0], 2'h0};

  // result formation
  always_comb begin
    c_op2  = r.index;
    c_addr = r.base;
    c_wb   = r.base;
    c_end  = r.base;
    c_wben = 1'b0;
    c_fen  = 4'h0;
    case (mode)
      AOG_M_OPERAND: begin
        case (src)
          AOG_S_IMM: c_op2 = r.imm;
          AOG_S_REG: c_op2 = r.index;
          default:   c_op2 = sh_res;
        endcase
      end
      AOG_M_WORD_BYTE, AOG_M_UNPRIV, AOG_M_HALFWORD, AOG_M_COPROC: begin
        c_wb = calc;
        c_end = c_addr;
        if (form == AOG_F_POST) begin
          c_addr = r.base;
          c_wben = !c_ill;
        end else if (form == AOG_F_PRE) begin
          c_addr = calc;
          c_wben = !c_ill;
        end else begin
          c_addr = calc;
        end
        c_end = c_addr;
      end
      AOG_M_MULTI_LOAD, AOG_M_MULTI_STORE: begin
        c_wben = 1'b1;
        case (seq)
          AOG_INC_AFTER: begin
            c_addr = r.base;
            c_end  = r.base + nbytes - 32'h4;
            c_wb   = r.base + nbytes;
          end
          AOG_INC_BEFORE: begin
            c_addr = r.base + 32'h4;
            c_end  = r.base + nbytes;
            c_wb   = r.base + nbytes;
          end
          AOG_DEC_AFTER: begin
            c_addr = r.base - nbytes + 32'h4;
            c_end  = r.base;
            c_wb   = r.base - nbytes;
          end
          default: begin
            c_addr = r.base - nbytes;
            c_end  = r.base - 32'h4;
            c_wb   = r.base - nbytes;
          end
        endcase
      end
      AOG_M_FIELDS: begin
        c_fen[M_CTL]    = r.ctrl[C_MASK + M_CTL];
        c_fen[M_EXT]    = r.ctrl[C_MASK + M_EXT];
        c_fen[M_FLAGS]  = r.ctrl[C_MASK + M_FLAGS];
        c_fen[M_STATUS] = r.ctrl[C_MASK + M_STATUS];
      end
      default: c_op2 = r.index;
    endcase
  end

  // read mux
  always_comb begin
    status = 32'h0;
    status[S_BUSY]  = (r.st != AOG_IDLE);
    status[S_DONE]  = r.done;
    status[S_ILL]   = r.illegal;
    status[S_CARRY] = r.carry;
    status[S_WBEN]  = r.wb_en;
    status[S_FEN +: 4] = r.fen;
    hit = 1'b1;
    case (paddr)
      AOG_CTRL:   rdval = r.ctrl;
      AOG_BASE:   rdval = r.base;
      AOG_INDEX:  rdval = r.index;
      AOG_SHREG:  rdval = r.shreg;
      AOG_IMM:    rdval = r.imm;
      AOG_CMD:    rdval = 32'h0;
      AOG_STATUS: rdval = status;
      AOG_OP2:    rdval = r.op2;
      AOG_ADDR:   rdval = r.addr;
      AOG_WBADDR: rdval = r.wb_addr;
      AOG_ENDADR: rdval = r.end_addr;
      default: begin
        rdval = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  assign acc = psel && penable;

  always_comb begin
    n = r;
    n.valid = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // one wait state, then the answer
    if (acc && !r.pready) begin
      n.pready = 1'b1;
      n.pslverr = !hit;
      n.prdata = pwrite ? 32'h0 : rdval;
    end
    if (acc && r.pready && pwrite && hit) begin
      case (paddr)
        AOG_CTRL:  n.ctrl = pwdata;
        AOG_BASE:  n.base = pwdata;
        AOG_INDEX: n.index = pwdata;
        AOG_SHREG: n.shreg = pwdata;
        AOG_IMM:   n.imm = pwdata;
        AOG_CMD: begin
          if (pwdata[CMD_GO] && r.st == AOG_IDLE) begin
            n.st = AOG_CALC;
            n.done = 1'b0;
          end
        end
        default: n.ctrl = r.ctrl;
      endcase
    end
    case (r.st)
      AOG_CALC: begin
        n.op2      = c_op2;
        n.carry    = sh_c;
        n.addr     = c_addr;
        n.wb_addr  = c_wb;
        n.end_addr = c_end;
        n.wb_en    = c_wben;
        n.illegal  = c_ill;
        n.fen      = c_fen;
        n.valid    = 1'b1;
        n.st       = AOG_DONE;
      end
      AOG_DONE: begin
        n.done = 1'b1;
        n.st = AOG_IDLE;
      end
      AOG_IDLE: n.done = n.done;
      default: n.st = AOG_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= AOG_IDLE;
    end else begin
      r <= n;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign second_operand = r.op2;
  assign shifter_carry  = r.carry;
  assign access_addr    = r.addr;
  assign writeback_addr = r.wb_addr;
  assign writeback_en   = r.wb_en;
  assign end_addr       = r.end_addr;
  assign field_en       = r.fen;
  assign illegal_form   = r.illegal;
  assign result_valid   = r.valid;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_imm_op2;
    r.st == AOG_CALC && mode == AOG_M_OPERAND && src == AOG_S_IMM
      |=> second_operand == $past(r.imm);
  endproperty
  a_imm_op2: assert property (p_imm_op2)
    else $error("immediate second operand wrong");

  property p_wb_imm;
    r.st == AOG_CALC && mode == AOG_M_WORD_BYTE && src == AOG_S_IMM && up
      |=> writeback_addr == $past(r.base) + {20'h0, $past(r.imm[11:0])};
  endproperty
  a_wb_imm: assert property (p_wb_imm)
    else $error("word/byte immediate offset wrong");

  property p_pre;
    r.st == AOG_CALC && mode == AOG_M_WORD_BYTE && form == AOG_F_PRE
      |=> writeback_en && access_addr == writeback_addr;
  endproperty
  a_pre: assert property (p_pre)
    else $error("pre-indexed address not written back");

  property p_post;
    r.st == AOG_CALC && mode == AOG_M_WORD_BYTE && form == AOG_F_POST
      |=> writeback_en && access_addr == $past(r.base);
  endproperty
  a_post: assert property (p_post)
    else $error("post-indexed access not at base");

  property p_unpriv;
    r.st == AOG_CALC && mode == AOG_M_UNPRIV && form == AOG_F_PRE
      |=> !writeback_en && illegal_form;
  endproperty
  a_unpriv: assert property (p_unpriv)
    else $error("unprivileged pre-index accepted");

  property p_half;
    r.st == AOG_CALC && mode == AOG_M_HALFWORD && src == AOG_S_SCALED
      |=> illegal_form && !writeback_en;
  endproperty
  a_half: assert property (p_half)
    else $error("halfword scaled offset accepted");

  property p_multi;
    r.st == AOG_CALC && mode == AOG_M_MULTI_LOAD && seq == AOG_DEC_BEFORE
      |=> access_addr == writeback_addr && end_addr == $past(r.base) - 32'h4;
  endproperty
  a_multi: assert property (p_multi)
    else $error("decrement-before addresses wrong");

  property p_cop;
    r.st == AOG_CALC && mode == AOG_M_COPROC && form == AOG_F_OFFSET && !up
      |=> access_addr == $past(r.base) - {22'h0, $past(r.imm[7:0]), 2'h0};
  endproperty
  a_cop: assert property (p_cop)
    else $error("coprocessor offset not scaled by four");

  property p_fields_hi;
    r.st == AOG_CALC && mode == AOG_M_FIELDS
      |=> field_en[3:2] == $past(r.ctrl[C_MASK + 2 +: 2]);
  endproperty
  a_fields_hi: assert property (p_fields_hi)
    else $error("control/extension enables wrong");

  property p_fields_lo;
    r.st == AOG_CALC && mode == AOG_M_FIELDS
      |=> field_en[1:0] == $past(r.ctrl[C_MASK +: 2]);
  endproperty
  a_fields_lo: assert property (p_fields_lo)
    else $error("flags/status enables wrong");

  property p_rrx;
    r.st == AOG_CALC && mode == AOG_M_OPERAND && src == AOG_S_SCALED &&
      kind == AOG_RRX |=> second_operand ==
      {$past(r.ctrl[C_CIN]), $past(r.index[31:1])} &&
      shifter_carry == $past(r.index[0]);
  endproperty
  a_rrx: assert property (p_rrx)
    else $error("extended rotate wrong");

  property p_handshake;
    acc && !pready |=> pready ##1 !pready;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("apb answer not one cycle");

  property p_valid;
    r.st == AOG_CALC |=> result_valid ##1 (!result_valid && r.done);
  endproperty
  a_valid: assert property (p_valid)
    else $error("result valid pulse wrong");

  c_unmapped: cover property (pready && pslverr);
  c_pre:      cover property (result_valid && writeback_en);
  c_multi:    cover property (r.st == AOG_CALC && mode == AOG_M_MULTI_STORE);
  c_fields:   cover property (result_valid && field_en == 4'hf);
endmodule

// File: design/aog_pkg.sv
// constants and types for the address and operand generator
// Summary of operation
// - second operand is immediate, register, or register shifted by imm/reg
// - word/byte offset is imm12, index register or scaled index, added/subbed
// - pre-indexed word/byte uses base+/-offset and writes it back
// - post-indexed word/byte accesses base, then updates base by offset
// - unprivileged word/byte allows offset and post forms only
// - halfword offset is imm8 or unscaled index, in all three forms
// - multiple transfers sequence IA, IB, DA, DB; stack aliases map to them
// - coprocessor offset is imm8 times four, in all three forms
// - field mask bit 3 enables control field, bit 2 extension field
// - field mask bit 0 enables flags field, bit 1 status field
package aog_pkg;
  localparam int unsigned AOG_AW = 8;
  // register byte offsets
  localparam logic [7:0] AOG_CTRL   = 8'h00;
  localparam logic [7:0] AOG_BASE   = 8'h04;
  localparam logic [7:0] AOG_INDEX  = 8'h08;
  localparam logic [7:0] AOG_SHREG  = 8'h0c;
  localparam logic [7:0] AOG_IMM    = 8'h10;
  localparam logic [7:0] AOG_CMD    = 8'h14;
  localparam logic [7:0] AOG_STATUS = 8'h18;
  localparam logic [7:0] AOG_OP2    = 8'h1c;
  localparam logic [7:0] AOG_ADDR   = 8'h20;
  localparam logic [7:0] AOG_WBADDR = 8'h24;
  localparam logic [7:0] AOG_ENDADR = 8'h28;
  localparam logic [31:0] AOG_RST   = 32'h0;
  // control register fields
  localparam int unsigned C_MODE  = 0;
  localparam int unsigned C_FORM  = 4;
  localparam int unsigned C_SRC   = 6;
  localparam int unsigned C_UP    = 8;
  localparam int unsigned C_KIND  = 9;
  localparam int unsigned C_BYREG = 12;
  localparam int unsigned C_CIN   = 13;
  localparam int unsigned C_MASK  = 16;
  localparam int unsigned C_SEQ   = 20;
  localparam int unsigned C_SHIMM = 24;
  localparam int unsigned SHIMM_W = 5;
  // field mask bits
  localparam int unsigned M_FLAGS  = 0;
  localparam int unsigned M_STATUS = 1;
  localparam int unsigned M_EXT    = 2;
  localparam int unsigned M_CTL    = 3;
  // status bits
  localparam int unsigned S_BUSY  = 0;
  localparam int unsigned S_DONE  = 1;
  localparam int unsigned S_ILL   = 2;
  localparam int unsigned S_CARRY = 3;
  localparam int unsigned S_WBEN  = 4;
  localparam int unsigned S_FEN   = 8;
  localparam int unsigned CMD_GO  = 0;
  // offset widths and scales
  localparam int unsigned OFS12_W = 12;
  localparam int unsigned OFS8_W  = 8;
  localparam int unsigned CNT_W   = 5;
  localparam int unsigned WORD_SH = 2;
  typedef enum logic [2:0] {
    AOG_M_OPERAND = 3'h0, AOG_M_WORD_BYTE = 3'h1, AOG_M_UNPRIV = 3'h2,
    AOG_M_HALFWORD = 3'h3, AOG_M_MULTI_LOAD = 3'h4,
    AOG_M_MULTI_STORE = 3'h5, AOG_M_COPROC = 3'h6, AOG_M_FIELDS = 3'h7
  } aog_mode_t;
  typedef enum logic [1:0] {
    AOG_F_OFFSET = 2'h0, AOG_F_PRE = 2'h1, AOG_F_POST = 2'h2
  } aog_form_t;
  typedef enum logic [1:0] {
    AOG_S_IMM = 2'h0, AOG_S_REG = 2'h1, AOG_S_SCALED = 2'h2
  } aog_src_t;
  typedef enum logic [2:0] {
    AOG_LSL = 3'h0, AOG_LSR = 3'h1, AOG_ASR = 3'h2, AOG_ROR = 3'h3,
    AOG_RRX = 3'h4
  } aog_kind_t;
  typedef enum logic [1:0] {
    AOG_INC_AFTER = 2'h0, AOG_INC_BEFORE = 2'h1,
    AOG_DEC_AFTER = 2'h2, AOG_DEC_BEFORE = 2'h3
  } aog_seq_t;
  // load stack aliases
  localparam aog_seq_t AOG_FULL_DESC  = AOG_INC_AFTER;
  localparam aog_seq_t AOG_EMPTY_DESC = AOG_INC_BEFORE;
  localparam aog_seq_t AOG_FULL_ASC   = AOG_DEC_AFTER;
  localparam aog_seq_t AOG_EMPTY_ASC  = AOG_DEC_BEFORE;
  typedef enum logic [1:0] {
    AOG_IDLE = 2'h0, AOG_CALC = 2'h1, AOG_DONE = 2'h3
  } aog_state_t;
endpackage

// File: design/aog_shifter.sv
// barrel shifter for the second operand and scaled index
`timescale 1ns/10ps
module aog_shifter import aog_pkg::*; (
  // operand
  input  wire logic [31:0] value,
  input  wire aog_kind_t   kind,
  input  wire logic [7:0]  amount,
  input  wire logic        carry_in,
  // result
  output logic      [31:0] result,
  output logic             carry_out
);
  logic [64:0] lw;
  logic [63:0] rw;
  logic [63:0] aw;
  logic [4:0]  rot;
  always_comb begin
    lw = {33'h0, value} << amount;
    rw = {value, 32'h0} >> amount;
    aw = 64'($signed({value, 32'h0}) >>> amount);
    rot = amount[4:0];
    result = value;
    carry_out = carry_in;
    if (kind == AOG_RRX) begin
      result = {carry_in, value[31:1]};
      carry_out = value[0];
    end else if (amount != 8'h0) begin
      case (kind)
        AOG_LSL: begin
          result = lw[31:0];
          carry_out = lw[32];
        end
        AOG_LSR: begin
          result = rw[63:32];
          carry_out = rw[31];
        end
        AOG_ASR: begin
          result = aw[63:32];
          carry_out = aw[31];
        end
        AOG_ROR: begin
          result = (value >> rot) | (value << (6'h20 - {1'b0, rot}));
          carry_out = result[31];
        end
        default: begin
          result = value;
          carry_out = carry_in;
        end
      endcase
    end
  end
endmodule

// File: sim/aog_lsu_model.sv
// load-store side model that follows base register writebacks
`timescale 1ns/10ps
module aog_lsu_model (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // results from the generator
  input wire logic        result_valid,
  input wire logic [31:0] writeback_addr,
  input wire logic        writeback_en
);
  int unsigned seen;
  logic [31:0] base_reg;

  // base register takes the writeback only when asked to
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 0;
      base_reg <= '0;
    end else if (result_valid === 1'b1) begin
      seen <= seen + 1;
      if (writeback_en === 1'b1) begin
        base_reg <= writeback_addr;
      end
    end
  end
endmodule

// File: sim/test_address_operand_generator.sv
// self-checking bench for the address and operand generator
`timescale 1ns/10ps
module test_address_operand_generator import aog_pkg::*; ();
  localparam logic [31:0] IDX     = 32'h8000_00f3;
  localparam logic [31:0] BASE    = 32'h0001_0000;
  localparam logic [31:0] MB      = 32'h0000_2000;
  localparam logic [31:0] F_CIN   = 32'h1 << C_CIN;
  localparam logic [31:0] F_BYREG = 32'h1 << C_BYREG;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] second_operand;
  logic        shifter_carry;
  logic [31:0] access_addr;
  logic [31:0] writeback_addr;
  logic        writeback_en;
  logic [31:0] end_addr;
  logic [3:0]  field_en;
  logic        illegal_form;
  logic        result_valid;
  int          miscompares;
  int          checks_done;
  int          ncalc;
  logic [31:0] rd;
  logic        err;
  logic [32:0] e;
  logic [31:0] o;
  logic [31:0] a;
  logic [1:0]  sr;
  logic        up;
  logic        inc;
  logic        bef;
  aog_seq_t    stk[4];

  aog_core aog_core_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .second_operand, .shifter_carry, .access_addr,
    .writeback_addr, .writeback_en, .end_addr, .field_en, .illegal_form,
    .result_valid
  );

  aog_lsu_model aog_lsu_model_i (
    .pclk, .presetn, .result_valid, .writeback_addr, .writeback_en
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [32:0] shf(logic [31:0] v, logic [2:0] k,
                                      logic [7:0] s, logic ci);
    logic [31:0] r;
    r = (v >> s) | (v << (32 - s));
    if (s == 0 && k != AOG_RRX) return {ci, v};
    case (k)
      AOG_LSL: return {1'b0, v} << s;
      AOG_LSR: return {v[s-1], v >> s};
      AOG_ASR: return {v[s-1], 32'($signed(v) >>> s)};
      AOG_ROR: return {r[31], r};
      default: return {v[0], ci, v[31:1]};
    endcase
  endfunction

  function automatic logic [31:0] cw(logic [2:0] md, logic [1:0] fm,
      logic [1:0] sc, logic u, logic [2:0] kd, logic [4:0] sh);
    return (32'(md) << C_MODE) | (32'(fm) << C_FORM) | (32'(sc) << C_SRC)
         | (32'(u) << C_UP) | (32'(kd) << C_KIND) | (32'(sh) << C_SHIMM);
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, idle cycle first so strobes never toggle twice
  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic calc(logic [31:0] c, b, x, s, m);
    int n;
    n = 0;
    apb(1'b1, AOG_CTRL, c);
    apb(1'b1, AOG_BASE, b);
    apb(1'b1, AOG_INDEX, x);
    apb(1'b1, AOG_SHREG, s);
    apb(1'b1, AOG_IMM, m);
    apb(1'b1, AOG_CMD, 32'h1);
    while (result_valid !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 10) miscompares++;
    @(posedge pclk);
    chk("pulse", result_valid, 32'h0);
    ncalc++;
  endtask

  task automatic chk_ab(logic [31:0] b, ofs, logic u, logic [1:0] fm,
                        logic ill);
    logic [31:0] s;
    s = u ? b + ofs : b - ofs;
    chk("illegal", illegal_form, ill);
    chk("wb_en", writeback_en, fm != AOG_F_OFFSET && !ill);
    if (!ill) begin
      chk("access", access_addr, fm == AOG_F_POST ? b : s);
      chk("end", end_addr, fm == AOG_F_POST ? b : s);
    end
    if (fm != AOG_F_OFFSET && !ill) begin
      chk("wb", writeback_addr, s);
      chk("base", aog_lsu_model_i.base_reg, s);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12000) @(posedge pclk);
    miscompares++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    miscompares = 0;
    checks_done = 0;
    ncalc = 0;
    stk = '{AOG_FULL_DESC, AOG_EMPTY_DESC, AOG_FULL_ASC, AOG_EMPTY_ASC};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AOG_CTRL, 32'h0);
    chk("ctrl", rd, AOG_RST);
    apb(1'b0, AOG_STATUS, 32'h0);
    chk("status", rd, AOG_RST);
    $display("test reset done");
    calc(cw(AOG_M_OPERAND, 0, AOG_S_IMM, 0, 0, 0), 0, IDX, 0, 32'hdead_beef);
    chk("op2", second_operand, 32'hdead_beef);
    calc(cw(AOG_M_OPERAND, 0, AOG_S_REG, 0, 0, 0), 0, IDX, 0, 0);
    chk("op2", second_operand, IDX);
    for (int k = 0; k < 5; k++) begin
      e = shf(IDX, 3'(k), 8'h5, 1'b1);
      calc(cw(AOG_M_OPERAND, 0, AOG_S_SCALED, 0, 3'(k), 5'h5) | F_CIN,
           0, IDX, 0, 0);
      chk("op2", second_operand, e[31:0]);
      chk("carry", shifter_carry, e[32]);
      e = shf(IDX, 3'(k), 8'h7, 1'b0);
      calc(cw(AOG_M_OPERAND, 0, AOG_S_SCALED, 0, 3'(k), 0) | F_BYREG,
           0, IDX, 32'h0000_0307, 0);
      chk("op2_reg", second_operand, e[31:0]);
      chk("carry_reg", shifter_carry, e[32]);
      // register amount of 32, upper bits of the amount register ignored
      e = shf(IDX, 3'(k), 8'h20, 1'b1);
      calc(cw(AOG_M_OPERAND, 0, AOG_S_SCALED, 0, 3'(k), 0) | F_BYREG | F_CIN,
           0, IDX, 32'h0000_ff20, 0);
      chk("op2_r32", second_operand, e[31:0]);
      chk("carry_r32", shifter_carry, e[32]);
      // immediate amount of zero passes the value and the carry through for every kind except RRX
      e = shf(IDX, 3'(k), 8'h0, 1'b1);
      calc(cw(AOG_M_OPERAND, 0, AOG_S_SCALED, 0, 3'(k), 0) | F_CIN,
           0, IDX, 0, 0);
      chk("op2_0", second_operand, e[31:0]);
      chk("carry_0", shifter_carry, e[32]);
    end
    $display("test operand done");
    for (int u = 0; u < 2; u++)
      for (int f = 0; f < 3; f++)
        for (int k = 0; k < 7; k++) begin
          sr = k > 4 ? 2'(k - 5) : AOG_S_SCALED;
          e = shf(IDX, 3'(k), 8'h3, 1'b1);
          o = k == 5 ? 32'h123 : k == 6 ? IDX : e[31:0];
          up = 1'((f + k) % 2);
          calc(cw(u ? AOG_M_UNPRIV : AOG_M_WORD_BYTE, 2'(f), sr, up,
               3'(k % 5), 5'h3) | F_CIN, BASE, IDX, 0, 32'h0000_f123);
          chk_ab(BASE, o, up, 2'(f), u == 1 && f == 1);
        end
    // reserved form and source codes in word/byte mode are flagged and never write back
    calc(cw(AOG_M_WORD_BYTE, 2'h3, AOG_S_IMM, 1'b1, 0, 0), BASE, IDX, 0, 0);
    chk_ab(BASE, 0, 1'b1, 2'h3, 1'b1);
    calc(cw(AOG_M_WORD_BYTE, AOG_F_OFFSET, 2'h3, 1'b1, 0, 0),
         BASE, IDX, 0, 0);
    chk_ab(BASE, 0, 1'b1, AOG_F_OFFSET, 1'b1);
    $display("test word byte done");
    for (int f = 0; f < 3; f++)
      for (int s = 0; s < 3; s++) begin
        calc(cw(AOG_M_HALFWORD, 2'(f), 2'(s), 1'(s), AOG_LSL, 5'h2),
             BASE, IDX, 0, 32'h0000_0a5c);
        chk_ab(BASE, s == 0 ? 32'h5c : IDX, 1'(s), 2'(f), s == 2);
      end
    for (int f = 0; f < 3; f++) begin
      calc(cw(AOG_M_COPROC, 2'(f), AOG_S_IMM, 1'(f), AOG_LSL, 0),
           BASE, IDX, 0, 32'h0000_0341);
      chk_ab(BASE, 32'h104, 1'(f), 2'(f), 1'b0);
    end
    $display("test halfword coprocessor done");
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", err, 32'h1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, AOG_ADDR, 32'hffff_ffff);
    apb(1'b0, AOG_ADDR, 32'h0);
    chk("read_only", rd, BASE);
    $display("test bus done");
    for (int m = 0; m < 8; m++) begin
      calc(cw(m > 3 ? AOG_M_MULTI_STORE : AOG_M_MULTI_LOAD, 0, 0, 0, 0, 0)
           | (32'(stk[m % 4]) << C_SEQ), MB, IDX, 0, 32'h25);
      inc = (m % 4) < 2;
      bef = m % 2;
      a = (inc ? MB : MB - 32'd20) + (inc == bef ? 32'h4 : 32'h0);
      chk("access", access_addr, a);
      chk("end", end_addr, a + 32'd16);
      chk("wb", writeback_addr, inc ? MB + 32'd20 : MB - 32'd20);
      chk("wb_en", writeback_en, 32'h1);
    end
    $display("test multiple done");
    for (int k = 0; k < 16; k++) begin
      calc(cw(AOG_M_FIELDS, 0, 0, 0, 0, 0) | (32'(k) << C_MASK),
           BASE, IDX, 0, 0);
      chk("ctl_ext", 32'(field_en[3:2]), 32'(k >> 2));
      chk("flg_sts", 32'(field_en[1:0]), 32'(k & 3));
    end
    $display("test fields done");
    apb(1'b0, AOG_STATUS, 32'h0);
    chk("status", rd, (32'h1 << S_DONE) | (32'hf << S_FEN));
    chk("pulses", aog_lsu_model_i.seen, ncalc);
    // second reset in mid-run clears results and control
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("op2_rst", second_operand, AOG_RST);
    chk("fen_rst", 32'(field_en), AOG_RST);
    apb(1'b0, AOG_CTRL, 32'h0);
    chk("ctrl_rst", rd, AOG_RST);
    $display("test reset again done");
    end_sim();
  end
endmodule
